//--- hw/gmr_pkg.sv
// types of the gyro control block
package gmr_pkg;

   typedef enum logic [1:0] {
      GMR_HOLD   = 2'h0,
      GMR_CAL    = 2'h1,
      GMR_SEARCH = 2'h3,
      GMR_RUN    = 2'h2
   } gmr_state_type;

   typedef enum logic [1:0] {
      GMR_R75  = 2'h0,
      GMR_R150 = 2'h1,
      GMR_R300 = 2'h2,
      GMR_R900 = 2'h3
   } gmr_range_type;

   function automatic logic [9:0] gmr_full_scale(input gmr_range_type r);
      case (r)
         GMR_R75:  gmr_full_scale = 10'h04B;
         GMR_R150: gmr_full_scale = 10'h096;
         GMR_R300: gmr_full_scale = 10'h12C;
         default:  gmr_full_scale = 10'h384;
      endcase
   endfunction

endpackage

//--- hw/gmr_regs.svh
// register offsets, field positions, reset values and timing counts of the gyro control block
`ifndef GMR_REGS_SVH
`define GMR_REGS_SVH

`define GMR_OFF_CTRL      12'h000
`define GMR_OFF_STATUS    12'h004
`define GMR_OFF_IRQ_STAT  12'h008
`define GMR_OFF_IRQ_MASK  12'h00C
`define GMR_OFF_TX_DATA   12'h010
`define GMR_OFF_RX_DATA   12'h014

`define GMR_CTRL_SPI_EN   0
`define GMR_CTRL_RESET    32'h0000_0001

`define GMR_IRQ_RUN       0
`define GMR_IRQ_RX        1
`define GMR_IRQ_FAULT     2
`define GMR_IRQ_W         3

`define GMR_TX_RESET      8'hFF

`define GMR_CLK_MHZ       20
`define GMR_CAL_LOAD_US   10
`define GMR_CAL_LOAD_CYC  (`GMR_CAL_LOAD_US * `GMR_CLK_MHZ)

`endif

//--- hw/gmr_spi.sv
// mode 0 serial slave, oversampled by the block clock
module gmr_spi #(
   parameter int W = 8
) (
   // clock and reset
   input  wire logic         clk_in,
   input  wire logic         rstn_in,
   // synchronised pins
   input  wire logic         sclk_in,
   input  wire logic         mosi_in,
   input  wire logic         ss_n_in,
   input  wire logic         enable_in,
   // byte side
   input  wire logic [W-1:0] tx_data_in,
   output logic              miso_out,
   output logic      [W-1:0] rx_data_out,
   output logic              rx_valid_out
);
   logic         sclk_d_r;
   logic         ss_d_r;
   logic [W-1:0] shift_r;
   logic [W-1:0] tx_r;
   logic [$clog2(W):0] cnt_r;
   logic         act;
   logic         rise;
   logic         fall;

   assign act  = enable_in && !ss_n_in;
   assign rise = act && sclk_in && !sclk_d_r;
   assign fall = act && !sclk_in && sclk_d_r;

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         sclk_d_r <= 1'b0;
         ss_d_r   <= 1'b1;
      end else begin
         sclk_d_r <= sclk_in;
         ss_d_r   <= ss_n_in;
      end
   end

   // sample on rising edge, shift out on falling edge
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         shift_r      <= '0;
         tx_r         <= '1;
         cnt_r        <= '0;
         rx_data_out  <= '0;
         rx_valid_out <= 1'b0;
      end else begin
         rx_valid_out <= 1'b0;
         if (!act) begin
            cnt_r <= '0;
            if (ss_d_r || !enable_in) begin
               tx_r <= tx_data_in;
            end
         end else if (rise) begin
            shift_r <= {shift_r[W-2:0], mosi_in};
            if (cnt_r == ($clog2(W)+1)'(W - 1)) begin
               cnt_r        <= '0;
               rx_data_out  <= {shift_r[W-2:0], mosi_in};
               rx_valid_out <= 1'b1;
            end else begin
               cnt_r <= cnt_r + 1'b1;
            end
         end else if (fall) begin
            if (cnt_r == '0) begin
               tx_r <= tx_data_in;
            end else begin
               tx_r <= {tx_r[W-2:0], 1'b1};
            end
         end
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         miso_out <= 1'b1;
      end else begin
         miso_out <= tx_r[W-1];
      end
   end
endmodule // gmr_spi

//--- hw/gmr_sync.sv
// two flip-flop synchroniser for levels from outside the clock domain
module gmr_sync #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         clk_in,
   input  wire logic         rstn_in,
   // level in and synchronised copy
   input  wire logic [W-1:0] d_in,
   output logic      [W-1:0] q_out
);
   logic [W-1:0] meta_r;

   // the first stage feeds only the second
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         meta_r <= '0;
         q_out  <= '0;
      end else begin
         meta_r <= d_in;
         q_out  <= meta_r;
      end
   end
endmodule // gmr_sync

//--- hw/gmr_top.sv
// gyro mode strap, reset sequencing, range capture, shared pins and register slave
`include "gmr_regs.svh"
module gmr_top #(
   parameter int CAL_CYC = `GMR_CAL_LOAD_CYC
) (
   // clock and reset
   input  wire logic        clk_in,
   input  wire logic        rstn_in,
   // apb slave
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [11:0] paddr_in,
   input  wire logic [31:0] pwdata_in,
   output logic      [31:0] prdata_out,
   output logic             pready_out,
   output logic             pslverr_out,
   // device pins
   input  wire logic        mode_strap_in,
   input  wire logic        gyro_reset_n_in,
   input  wire logic        range_pick_a_in,
   input  wire logic        range_pick_b_in,
   input  wire logic        test_sel_n_in,
   output logic             health_out,
   // analogue core
   input  wire logic        resonance_locked_in,
   input  wire logic        fault_in,
   input  wire logic [1:0]  cal_range_in,
   output logic             cal_load_out,
   output logic             commanded_self_test_out,
   output logic             rate_valid_out,
   output logic      [1:0]  range_code_out,
   output logic      [9:0]  range_fs_out,
   // interrupt
   output logic             irq_out
);
   localparam logic [11:0] CAL_LAST = 12'(CAL_CYC - 1);

   logic                  rst_n_r;
   logic [6:0]            pins_s;
   logic                  mode_s;
   logic                  grst_s;
   logic                  pick_a_s;
   logic                  pick_b_s;
   logic                  tsel_s;
   logic                  lock_s;
   logic                  fault_s;
   gmr_pkg::gmr_state_type st_r;
   logic [11:0]           cnt_r;
   logic                  mode_r;
   gmr_pkg::gmr_range_type range_r;
   logic [31:0]           ctrl_r;
   logic [`GMR_IRQ_W-1:0] stat_r;
   logic [`GMR_IRQ_W-1:0] mask_r;
   logic [7:0]            tx_r;
   logic [7:0]            rx_data;
   logic                  rx_valid;
   logic                  miso;
   logic                  spi_en;
   logic                  wr;
   logic                  rd;
   logic                  hit;
   logic [`GMR_IRQ_W-1:0] ev;
   logic                  run_d_r;

   // reset release through two flip-flops
   // assert is immediate, release waits two edges so no flop leaves reset mid-setup
   gmr_sync #(.W(1)) u_rst (
      .clk_in  (clk_in),
      .rstn_in (rstn_in),
      .d_in    (1'b1),
      .q_out   (rst_n_r)
   );

   gmr_sync #(.W(7)) u_pins (
      .clk_in  (clk_in),
      .rstn_in (rst_n_r),
      .d_in    ({fault_in, resonance_locked_in, test_sel_n_in, range_pick_b_in,
                 range_pick_a_in, gyro_reset_n_in, mode_strap_in}),
      .q_out   (pins_s)
   );
   assign mode_s   = pins_s[0];
   assign grst_s   = pins_s[1];
   assign pick_a_s = pins_s[2];
   assign pick_b_s = pins_s[3];
   assign tsel_s   = pins_s[4];
   assign lock_s   = pins_s[5];
   assign fault_s  = pins_s[6];

   // sequencer: a low reset pin forces preset state from any state
   always_ff @(posedge clk_in or negedge rst_n_r) begin
      if (!rst_n_r) begin
         st_r  <= gmr_pkg::GMR_HOLD;
         cnt_r <= 12'h000;
      end else if (!grst_s) begin
         st_r  <= gmr_pkg::GMR_HOLD;
         cnt_r <= 12'h000;
      end else begin
         case (st_r)
            gmr_pkg::GMR_HOLD: begin
               st_r  <= gmr_pkg::GMR_CAL;
               cnt_r <= 12'h000;
            end
            gmr_pkg::GMR_CAL: begin
               if (cnt_r == CAL_LAST) begin
                  st_r <= gmr_pkg::GMR_SEARCH;
               end else begin
                  cnt_r <= cnt_r + 12'h001;
               end
            end
            gmr_pkg::GMR_SEARCH: begin
               if (lock_s) begin
                  st_r <= gmr_pkg::GMR_RUN;
               end
            end
            gmr_pkg::GMR_RUN: begin
               st_r <= gmr_pkg::GMR_RUN;
            end
            default: begin
               st_r <= gmr_pkg::GMR_HOLD;
            end
         endcase
      end
   end

   // strap and range are caught once, at reset pin release, then frozen
   always_ff @(posedge clk_in or negedge rst_n_r) begin
      if (!rst_n_r) begin
         mode_r  <= 1'b0;
         range_r <= gmr_pkg::GMR_R75;
      end else if (st_r == gmr_pkg::GMR_HOLD && grst_s) begin
         mode_r <= mode_s;
         if (mode_s) begin
            range_r <= gmr_pkg::gmr_range_type'(cal_range_in);
         end else begin
            range_r <= gmr_pkg::gmr_range_type'({pick_b_s, pick_a_s});
         end
      end
   end

   assign cal_load_out   = (st_r == gmr_pkg::GMR_CAL);
   assign rate_valid_out = (st_r == gmr_pkg::GMR_RUN);
   assign range_code_out = range_r;
   assign range_fs_out   = gmr_pkg::gmr_full_scale(range_r);

   // serial slave only listens in serial mode with the reset pin high
   assign spi_en = mode_r && grst_s && ctrl_r[`GMR_CTRL_SPI_EN];

   gmr_spi #(.W(8)) u_spi (
      .clk_in       (clk_in),
      .rstn_in      (rst_n_r),
      .sclk_in      (pick_a_s),
      .mosi_in      (pick_b_s),
      .ss_n_in      (tsel_s),
      .enable_in    (spi_en),
      .tx_data_in   (tx_r),
      .miso_out     (miso),
      .rx_data_out  (rx_data),
      .rx_valid_out (rx_valid)
   );

   // self test in analogue mode while test pin is low and reset pin is high
   always_ff @(posedge clk_in or negedge rst_n_r) begin
      if (!rst_n_r) begin
         commanded_self_test_out <= 1'b0;
      end else begin
         commanded_self_test_out <= !mode_r && !tsel_s && grst_s;
      end
   end

   // in analogue mode health is false during start up, on fault and under self test; in serial mode it is high or carries miso
   always_ff @(posedge clk_in or negedge rst_n_r) begin
      if (!rst_n_r) begin
         health_out <= 1'b0;
      end else if (mode_r) begin
         health_out <= tsel_s ? 1'b1 : miso;
      end else begin
         health_out <= rate_valid_out && !fault_s && tsel_s;
      end
   end

   // apb: zero wait states, error on unmapped offsets
   assign pready_out = 1'b1;
   assign wr = psel_in && penable_in && pwrite_in;
   assign rd = psel_in && !pwrite_in;
   always_comb begin
      case (paddr_in)
         `GMR_OFF_CTRL, `GMR_OFF_STATUS, `GMR_OFF_IRQ_STAT,
         `GMR_OFF_IRQ_MASK, `GMR_OFF_TX_DATA, `GMR_OFF_RX_DATA: hit = 1'b1;
         default: hit = 1'b0;
      endcase
   end
   assign pslverr_out = psel_in && penable_in && !hit;

   always_ff @(posedge clk_in or negedge rst_n_r) begin
      if (!rst_n_r) begin
         ctrl_r <= `GMR_CTRL_RESET;
         mask_r <= '0;
         tx_r   <= `GMR_TX_RESET;
      end else if (wr) begin
         if (paddr_in == `GMR_OFF_CTRL) begin
            ctrl_r <= {31'h0000_0000, pwdata_in[`GMR_CTRL_SPI_EN]};
         end
         if (paddr_in == `GMR_OFF_IRQ_MASK) begin
            mask_r <= pwdata_in[`GMR_IRQ_W-1:0];
         end
         if (paddr_in == `GMR_OFF_TX_DATA) begin
            tx_r <= pwdata_in[7:0];
         end
      end
   end

   // sticky events; a set in the clearing cycle wins
   always_ff @(posedge clk_in or negedge rst_n_r) begin
      if (!rst_n_r) begin
         run_d_r <= 1'b0;
      end else begin
         run_d_r <= rate_valid_out;
      end
   end
   assign ev = {fault_s && rate_valid_out, rx_valid, rate_valid_out && !run_d_r};
   always_ff @(posedge clk_in or negedge rst_n_r) begin
      if (!rst_n_r) begin
         stat_r <= '0;
      end else if (wr && paddr_in == `GMR_OFF_IRQ_STAT) begin
         stat_r <= (stat_r & ~pwdata_in[`GMR_IRQ_W-1:0]) | ev;
      end else begin
         stat_r <= stat_r | ev;
      end
   end
   assign irq_out = |(stat_r & mask_r);

   always_ff @(posedge clk_in or negedge rst_n_r) begin
      if (!rst_n_r) begin
         prdata_out <= 32'h0000_0000;
      end else if (rd && !penable_in) begin
         case (paddr_in)
            `GMR_OFF_CTRL:     prdata_out <= ctrl_r;
            `GMR_OFF_STATUS:   prdata_out <= {24'h00_0000, grst_s, lock_s, range_r, mode_r,
                                              1'b0, st_r};
            `GMR_OFF_IRQ_STAT: prdata_out <= {29'h0000_0000, stat_r};
            `GMR_OFF_IRQ_MASK: prdata_out <= {29'h0000_0000, mask_r};
            `GMR_OFF_TX_DATA:  prdata_out <= {24'h00_0000, tx_r};
            `GMR_OFF_RX_DATA:  prdata_out <= {24'h00_0000, rx_data};
            default:           prdata_out <= 32'h0000_0000;
         endcase
      end
   end

   // checks
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_r);

   property p_hold;
      !grst_s |=> st_r == gmr_pkg::GMR_HOLD && !rate_valid_out;
   endproperty
   a_hold: assert property (p_hold) else $error("left preset state under reset");

   property p_release;
      (st_r == gmr_pkg::GMR_HOLD && grst_s) ##1 grst_s |-> cal_load_out;
   endproperty
   a_release: assert property (p_release) else $error("no calibration load on release");

   property p_run_order;
      $rose(rate_valid_out) |-> $past(st_r) == gmr_pkg::GMR_SEARCH && $past(lock_s);
   endproperty
   a_run_order: assert property (p_run_order) else $error("run without resonance");

   property p_range_ana;
      (st_r == gmr_pkg::GMR_HOLD && grst_s && !mode_s)
         |=> range_r == {$past(pick_b_s), $past(pick_a_s)} && !mode_r;
   endproperty
   a_range_ana: assert property (p_range_ana) else $error("analogue range not latched");

   property p_range_dig;
      (st_r == gmr_pkg::GMR_HOLD && grst_s && mode_s)
         |=> range_r == $past(cal_range_in) && mode_r;
   endproperty
   a_range_dig: assert property (p_range_dig) else $error("serial range not from calibration");

   property p_frozen;
      (st_r != gmr_pkg::GMR_HOLD && $past(st_r) != gmr_pkg::GMR_HOLD)
         |-> $stable(range_r) && $stable(mode_r);
   endproperty
   a_frozen: assert property (p_frozen) else $error("range or mode changed in operation");

   property p_spi_quiet;
      !grst_s ##1 !grst_s |-> !rx_valid;
   endproperty
   a_spi_quiet: assert property (p_spi_quiet) else $error("serial byte taken under reset");

   property p_fs;
      range_fs_out == 10'h04B || range_fs_out == 10'h096 ||
      range_fs_out == 10'h12C || range_fs_out == 10'h384;
   endproperty
   a_fs: assert property (p_fs) else $error("bad full scale");

   property p_selftest;
      mode_r |=> !commanded_self_test_out;
   endproperty
   a_selftest: assert property (p_selftest) else $error("self test in serial mode");

   property p_health;
      (!mode_r && (fault_s || !rate_valid_out)) |=> !health_out;
   endproperty
   a_health: assert property (p_health) else $error("health high on failure");

   c_run_ana: cover property (rate_valid_out && !mode_r);
   c_run_dig: cover property (rate_valid_out && mode_r);
   c_rx:      cover property (rx_valid);
   c_irq:     cover property ($rose(irq_out));
endmodule // gmr_top

//--- test/gmr_host_model.sv
// host side model: serial master in serial mode, static pin driver in analogue mode
module gmr_host_model (
   // pins towards the device
   output logic      sclk_out,
   output logic      mosi_out,
   output logic      ss_n_out,
   input  wire logic miso_in
);
   timeunit 1ns;
   timeprecision 1ns;

   initial begin
      sclk_out = 1'b0;
      mosi_out = 1'b0;
      ss_n_out = 1'b1;
   end

   // analogue mode: picks and self test held as static levels
   task automatic set_pins(input logic a, input logic b, input logic t_n);
      sclk_out <= a;
      mosi_out <= b;
      ss_n_out <= t_n;
   endtask

   // mode 0, msb first, clock low outside frames
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      int i;
      #37 ss_n_out = 1'b0;
      for (i = 7; i >= 0; i--) begin
         mosi_out = tx[i];
         #200 sclk_out = 1'b1;
         // late sample: the slave moves its data only after the falling edge
         #50 rx[i] = miso_in;
         #150 sclk_out = 1'b0;
      end
      #200 ss_n_out = 1'b1;
      // a released data line never keeps showing the last bit
      mosi_out = ~tx[0];
   endtask
endmodule // gmr_host_model

//--- test/testbench.sv
// self-checking bench of the gyro control block
`include "gmr_regs.svh"
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int CAL = 4;

   logic        clk_in, rstn_in, psel_in, penable_in, pwrite_in;
   logic [11:0] paddr_in;
   logic [31:0] pwdata_in, prdata_out;
   logic        pready_out, pslverr_out, mode_strap_in, gyro_reset_n_in;
   logic        sclk, mosi, ss_n, health_out, resonance_locked_in, fault_in;
   logic [1:0]  cal_range_in, range_code_out;
   logic        cal_load_out, commanded_self_test_out, rate_valid_out, irq_out;
   logic [9:0]  range_fs_out;
   int          mismatches, comparisons, seed, r, cc;
   int          irq_m;
   int          fs[4] = '{75, 150, 300, 900};
   logic [7:0]  sent_q[$];
   logic [7:0]  txb, m, got;

   gmr_top #(.CAL_CYC(CAL)) gmr_top_i (
      .clk_in(clk_in), .rstn_in(rstn_in), .psel_in(psel_in), .penable_in(penable_in),
      .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
      .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
      .mode_strap_in(mode_strap_in), .gyro_reset_n_in(gyro_reset_n_in),
      .range_pick_a_in(sclk), .range_pick_b_in(mosi), .test_sel_n_in(ss_n),
      .health_out(health_out), .resonance_locked_in(resonance_locked_in),
      .fault_in(fault_in), .cal_range_in(cal_range_in), .cal_load_out(cal_load_out),
      .commanded_self_test_out(commanded_self_test_out), .rate_valid_out(rate_valid_out),
      .range_code_out(range_code_out), .range_fs_out(range_fs_out), .irq_out(irq_out));

   gmr_host_model gmr_host_model_i (
      .sclk_out(sclk), .mosi_out(mosi), .ss_n_out(ss_n), .miso_in(health_out));

   initial begin
      clk_in = 1'b0;
      forever #25 clk_in = ~clk_in;
   end

   task automatic final_report;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   task automatic fail(input string msg);
      mismatches++;
      $display("Error at %0t: %s", $time, msg);
   endtask

   task automatic chk_word(input logic [31:0] g, input logic [31:0] e, input string w);
      comparisons++;
      if (g !== e) fail($sformatf("%s got %h expected %h", w, g, e));
   endtask

   task automatic chk_bit(input logic g, input logic e, input string w);
      comparisons++;
      if (g !== e) fail($sformatf("%s got %b expected %b", w, g, e));
   endtask

   // one apb transfer, entered just after a rising edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
      int n;
      psel_in   <= 1'b1;
      pwrite_in <= wr;
      paddr_in  <= a;
      pwdata_in <= wd;
      @(posedge clk_in);
      penable_in <= 1'b1;
      for (n = 0; n < 16; n++) begin
         @(posedge clk_in);
         if (pready_out === 1'b1) break;
      end
      if (n == 16) begin
         fail("apb timeout");
         final_report();
      end
      rd = prdata_out;
      err = pslverr_out;
      psel_in    <= 1'b0;
      penable_in <= 1'b0;
      @(posedge clk_in);
   endtask

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] e, input logic ee);
      logic [31:0] d;
      logic        er;
      apb(1'b0, a, 32'h0, d, er);
      chk_word(d, e, "read data");
      chk_bit(er, ee, "slave error");
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] v);
      logic [31:0] d;
      logic        er;
      apb(1'b1, a, v, d, er);
   endtask

   function automatic logic [31:0] run_status(input logic md, input logic [1:0] rg);
      return {24'h0, 1'b1, 1'b1, rg, md, 1'b0, 2'h2};
   endfunction

   // hold, release, count calibration, then lock and wait for valid rate
   task automatic boot(input logic strap, input logic [1:0] pick, input logic [1:0] cal);
      int n;
      int vcnt;
      gyro_reset_n_in     <= 1'b0;
      resonance_locked_in <= 1'b0;
      mode_strap_in       <= strap;
      cal_range_in        <= cal;
      if (strap) gmr_host_model_i.set_pins(1'b0, 1'b0, 1'b1);
      else gmr_host_model_i.set_pins(pick[0], pick[1], 1'b1);
      repeat (6) @(posedge clk_in);
      chk_bit(rate_valid_out, 1'b0, "valid while held");
      chk_bit(cal_load_out, 1'b0, "load while held");
      gyro_reset_n_in <= 1'b1;
      cc = 0;
      vcnt = 0;
      for (n = 0; n < 20; n++) begin
         @(negedge clk_in);
         if (cal_load_out === 1'b1) cc++;
         if (rate_valid_out !== 1'b0) vcnt++;
      end
      chk_word(32'(cc), 32'(CAL), "calibration cycles");
      chk_word(32'(vcnt), 32'h0, "valid before lock");
      @(posedge clk_in);
      resonance_locked_in <= 1'b1;
      for (n = 0; n < 20 && rate_valid_out !== 1'b1; n++) @(posedge clk_in);
      if (n == 20) begin
         fail("no run state");
         final_report();
      end
      @(posedge clk_in);
      irq_m = irq_m | 1;
   endtask

   initial begin
      seed = 32'h4fae;
      mismatches = 0;
      comparisons = 0;
      irq_m = 0;
      rstn_in = 1'b0;
      psel_in = 1'b0;
      penable_in = 1'b0;
      pwrite_in = 1'b0;
      paddr_in = 12'h000;
      pwdata_in = 32'h0;
      gyro_reset_n_in = 1'b0;
      mode_strap_in = 1'b0;
      resonance_locked_in = 1'b0;
      fault_in = 1'b0;
      cal_range_in = 2'h0;
      repeat (8) @(posedge clk_in);
      rstn_in <= 1'b1;
      repeat (4) @(posedge clk_in);
      rd_chk(`GMR_OFF_CTRL, `GMR_CTRL_RESET, 1'b0);
      rd_chk(`GMR_OFF_IRQ_MASK, 32'h0, 1'b0);
      rd_chk(`GMR_OFF_TX_DATA, {24'h0, `GMR_TX_RESET}, 1'b0);
      rd_chk(12'h0FC, 32'h0, 1'b1);
      $display("test register reset done");
      for (r = 0; r < 4; r++) begin
         boot(1'b0, 2'(r), ~2'(r));
         chk_word({30'h0, range_code_out}, 32'(r), "range code");
         chk_word({22'h0, range_fs_out}, 32'(fs[r]), "full scale");
         rd_chk(`GMR_OFF_STATUS, run_status(1'b0, 2'(r)), 1'b0);
         chk_bit(health_out, 1'b1, "healthy");
         gmr_host_model_i.set_pins(~r[0], ~r[1], 1'b1);
         repeat (6) @(posedge clk_in);
         chk_word({30'h0, range_code_out}, 32'(r), "range kept");
      end
      $display("test analogue ranges done");
      gmr_host_model_i.set_pins(1'b1, 1'b1, 1'b0);
      repeat (6) @(posedge clk_in);
      chk_bit(commanded_self_test_out, 1'b1, "self test on");
      chk_bit(health_out, 1'b0, "health in self test");
      gmr_host_model_i.set_pins(1'b1, 1'b1, 1'b1);
      repeat (6) @(posedge clk_in);
      chk_bit(commanded_self_test_out, 1'b0, "self test off");
      wr(`GMR_OFF_IRQ_STAT, 32'h7);
      irq_m = 0;
      fault_in <= 1'b1;
      repeat (6) @(posedge clk_in);
      chk_bit(health_out, 1'b0, "health on fault");
      fault_in <= 1'b0;
      irq_m = irq_m | 4;
      rd_chk(`GMR_OFF_IRQ_STAT, 32'(irq_m), 1'b0);
      chk_bit(irq_out, 1'b0, "masked interrupt");
      wr(`GMR_OFF_IRQ_MASK, 32'h4);
      chk_bit(irq_out, 1'b1, "unmasked interrupt");
      wr(`GMR_OFF_IRQ_STAT, 32'h4);
      irq_m = 0;
      chk_bit(irq_out, 1'b0, "cleared interrupt");
      $display("test self test and fault done");
      gyro_reset_n_in <= 1'b0;
      mode_strap_in <= 1'b1;
      repeat (6) @(posedge clk_in);
      gmr_host_model_i.xfer(8'hA5, got);
      @(posedge clk_in);
      rd_chk(`GMR_OFF_IRQ_STAT, 32'h0, 1'b0);
      boot(1'b1, 2'h0, 2'($random(seed)));
      chk_word({30'h0, range_code_out}, {30'h0, cal_range_in}, "serial range");
      rd_chk(`GMR_OFF_STATUS, run_status(1'b1, cal_range_in), 1'b0);
      chk_bit(health_out, 1'b1, "idle data out");
      wr(`GMR_OFF_IRQ_STAT, 32'h7);
      irq_m = 0;
      wr(`GMR_OFF_IRQ_MASK, 32'h2);
      txb = 8'($random(seed));
      wr(`GMR_OFF_TX_DATA, {24'h0, txb});
      repeat (2) begin
         m = 8'($random(seed));
         sent_q.push_back(m);
         gmr_host_model_i.xfer(m, got);
         repeat (4) @(posedge clk_in);
         irq_m = irq_m | 2;
         chk_word({24'h0, got}, {24'h0, txb}, "byte to host");
         rd_chk(`GMR_OFF_RX_DATA, {24'h0, sent_q.pop_front()}, 1'b0);
         rd_chk(`GMR_OFF_IRQ_STAT, 32'(irq_m), 1'b0);
         chk_bit(irq_out, 1'b1, "byte interrupt");
      end
      wr(`GMR_OFF_IRQ_STAT, 32'h2);
      wr(`GMR_OFF_CTRL, 32'h0);
      gmr_host_model_i.xfer(8'h3C, got);
      @(posedge clk_in);
      rd_chk(`GMR_OFF_IRQ_STAT, 32'h0, 1'b0);
      chk_bit(irq_out, 1'b0, "no interrupt when disabled");
      wr(`GMR_OFF_CTRL, 32'h1);
      gyro_reset_n_in <= 1'b0;
      repeat (6) @(posedge clk_in);
      gmr_host_model_i.xfer(8'h5A, got);
      @(posedge clk_in);
      rd_chk(`GMR_OFF_IRQ_STAT, 32'h0, 1'b0);
      $display("test serial mode done");
      final_report();
   end

   initial begin
      #2000000;
      fail("run timeout");
      final_report();
   end
endmodule // testbench
